// >>> rtl/cdt_pkg.sv
// Package: register map, field layout and codes of the cascadable dual timer
package cdt_pkg;
  localparam int ADDR_W   = 4;
  localparam int DATA_W   = 8;
  localparam int NUM_TAPS = 7;
  localparam int ST_W     = 3;

  // Register indices
  localparam logic [3:0] REG_CTL_LO = 4'h0;
  localparam logic [3:0] REG_CTL_HI = 4'h1;
  localparam logic [3:0] REG_PER_LO = 4'h2;
  localparam logic [3:0] REG_PER_HI = 4'h3;
  localparam logic [3:0] REG_WID_LO = 4'h4;
  localparam logic [3:0] REG_WID_HI = 4'h5;
  localparam logic [3:0] REG_AUX    = 4'h6;
  localparam logic [3:0] REG_STAT   = 4'h7;
  localparam logic [3:0] REG_MASK   = 4'h8;
  localparam logic [3:0] REG_CNT_LO = 4'h9;
  localparam logic [3:0] REG_CNT_HI = 4'hA;

  // Control register fields
  localparam int CTL_MODE_LSB = 0;
  localparam int CTL_RUN_BIT  = 3;
  localparam int CTL_CK_LSB   = 4;
  localparam int CTL_FF_BIT   = 7;
  localparam int AUX_REDIR_BIT = 0;

  // Status and mask bits
  localparam int ST_MATCH_LO = 0;
  localparam int ST_MATCH_HI = 1;
  localparam int ST_ILLEGAL  = 2;

  // Reset values
  localparam logic [7:0]      CTL_RST  = 8'h00;
  localparam logic [7:0]      PER_RST  = 8'hFF;
  localparam logic [7:0]      WID_RST  = 8'h00;
  localparam logic [7:0]      AUX_RST  = 8'h00;
  localparam logic [ST_W-1:0] STAT_RST = 3'h0;
  localparam logic [ST_W-1:0] MASK_RST = 3'h0;

  // Mode codes
  localparam logic [2:0] MODE_TIMER   = 3'h0;
  localparam logic [2:0] MODE_PDO     = 3'h1;
  localparam logic [2:0] MODE_PWM8    = 3'h2;
  localparam logic [2:0] MODE_CASC_LO = 3'h3;
  localparam logic [2:0] MODE_T16     = 3'h4;
  localparam logic [2:0] MODE_WARM    = 3'h5;
  localparam logic [2:0] MODE_PWM16   = 3'h6;
  localparam logic [2:0] MODE_PPG16   = 3'h7;

  // Clock-select codes
  localparam logic [2:0] CK_TAP0 = 3'h0;
  localparam logic [2:0] CK_TAP3 = 3'h3;
  localparam logic [2:0] CK_FS   = 3'h4;
  localparam logic [2:0] CK_FC2  = 3'h5;
  localparam logic [2:0] CK_FC   = 3'h6;
  localparam logic [2:0] CK_PIN  = 3'h7;
endpackage

// >>> rtl/cdt_count8.sv
// One 8-bit up-counter stage with clear and carry
`timescale 1ns/10ps
module cdt_count8 (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  // Control
  input  wire logic       inc,
  input  wire logic       clr,
  // Status
  output logic [7:0]      cnt,
  output logic            carry
);
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;

  // Clear beats increment so a match restarts from zero
  assign cnt_d = clr ? 8'h00 : (inc ? cnt_q + 8'h01 : cnt_q);
  assign carry = inc & (cnt_q == 8'hFF);
  assign cnt   = cnt_q;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule

// >>> rtl/cdt_timer_top.sv
// Cascadable dual 8-bit timer with register port, legality checks and interrupt
//
// Overview of operation
// RL1 - Each counter: control, period, width registers
// RL2 - Software keeps lower fields stable while running
// RL3 - Stop write keeps lower mode, clock select
// RL4 - Stop write keeps upper mode, clock, flip-flop
// RL5 - Cascade needs lower mode 011
// RL6 - Cascade: lower clock select, upper run/flip-flop
// RL7 - Upper mode 1xx clocks on lower overflow
// RL8 - Redirect bit set suppresses upper pin pulses
// RL9 - Slow/sleep: fc only for warm-up
// RL10 - Normal modes: legal taps per mode
// RL11 - Slow modes: slowest tap, fc warm-up, pin
// RL12 - Software keeps 8-bit period, width in range
// RL13 - 16-bit timer period 1 to 65535
// RL14 - Warm-up period 256 to 65535; code matches multiples of 256 only
// RL15 - 16-bit width 2 to 65534
// RL16 - PROGRAMMABLE_PULSE_MODE width plus one below period
// RL17 - Timer match: interrupt, clear, continue counting
// RL18 - Event counter counts pin falling edges
// RL19 - Illegal source at start is refused, flagged
//
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/10ps
module cdt_timer_top (
  // Clock and reset
  input  wire logic                         clk_sys,
  input  wire logic                         rst_b,
  // Register port
  input  wire logic [cdt_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [cdt_pkg::DATA_W-1:0]   reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic      [cdt_pkg::DATA_W-1:0]   reg_rdata,
  // Power mode and clock taps
  input  wire logic                         slow_power_mode,
  input  wire logic [cdt_pkg::NUM_TAPS-1:0] src_tick,
  input  wire logic                         upper_pin_in,
  // Outputs
  output logic                              lower_timer_out,
  output logic                              upper_timer_out,
  output logic                              irq
);
  import cdt_pkg::*;

  logic [7:0]      ctl_q [2];
  logic [7:0]      per_q [2];
  logic [7:0]      wid_q [2];
  logic [7:0]      cnt [2];
  logic [7:0]      cnt_nx [2];
  logic [2:0]      mode [2];
  logic [2:0]      ck [2];
  logic [1:0]      run;
  logic [1:0]      go;
  logic [1:0]      ok_now;
  logic [1:0]      inc;
  logic [1:0]      clr;
  logic [1:0]      carry;
  logic [1:0]      match8;
  logic [1:0]      ctl_wr;
  logic [1:0]      start_bad;
  logic [7:0]      aux_q;
  logic [ST_W-1:0] stat_q;
  logic [ST_W-1:0] stat_d;
  logic [ST_W-1:0] mask_q;
  logic [ST_W-1:0] ev;
  logic [7:0]      rdata_q;
  logic [7:0]      rd_mux;
  logic [7:0]      taps;
  logic            pin_q;
  logic            pin_fall;
  logic            casc;
  logic            m16;
  logic [15:0]     c16;
  logic [15:0]     c16_nx;
  logic [15:0]     tgt16;
  logic [15:0]     w16;
  logic            wave_lo;
  logic            wave_hi;
  logic            out_lo_q;
  logic            out_hi_q;

  // Source clock legality per mode and power mode
  function automatic logic legal_src(input logic [2:0] md, input logic [2:0] cs,
                                     input logic slow, input logic up);
    logic r;
    r = 1'b0;
    case (md)
      MODE_TIMER: begin
        if (cs == CK_PIN) begin
          r = up; // RL10 RL11
        end else begin
          r = slow ? (cs == CK_TAP0) : (cs <= CK_TAP3); // RL10 RL11
        end
      end
      MODE_PDO, MODE_PPG16: begin
        r = slow ? (cs == CK_TAP0) : (cs <= CK_TAP3); // RL10 RL11
      end
      MODE_T16: begin
        r = (cs == CK_PIN) || (slow ? (cs == CK_TAP0) : (cs <= CK_TAP3)); // RL10 RL11
      end
      MODE_PWM8, MODE_PWM16: begin
        r = slow ? (cs == CK_TAP0 || cs == CK_FS) : (cs <= CK_FC2);
      end
      MODE_WARM: begin
        r = slow ? (cs == CK_FC) : (cs == CK_FS); // RL9 RL10 RL11
      end
      MODE_CASC_LO: begin
        // Lower half of a cascade only; the upper counter has no such mode
        r = !up; // RL19
      end
      default: begin
        r = 1'b0;
      end
    endcase
    // 16-bit modes exist on the upper counter only
    if (md[2] && !up) begin
      r = 1'b0; // RL19
    end
    return r;
  endfunction

  // Field decode
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_fld
      assign mode[gi]   = ctl_q[gi][CTL_MODE_LSB +: 3];
      assign ck[gi]     = ctl_q[gi][CTL_CK_LSB +: 3];
      assign run[gi]    = ctl_q[gi][CTL_RUN_BIT];
      assign cnt_nx[gi] = cnt[gi] + 8'h01;
    end
  endgenerate

  assign casc     = (mode[0] == MODE_CASC_LO) && mode[1][2]; // RL5
  assign pin_fall = pin_q & ~upper_pin_in; // RL18
  assign taps     = {pin_fall, src_tick};

  // Cascade takes start control from the upper run bit
  assign go[0] = casc ? run[1] : (run[0] && (mode[0] != MODE_CASC_LO)); // RL6
  assign go[1] = run[1]; // RL6

  // Sources re-checked every cycle, so a power-mode change cannot feed an unlisted clock
  assign ok_now[1] = legal_src(mode[1], mode[1][2] ? ck[0] : ck[1], slow_power_mode, 1'b1); // RL19
  assign ok_now[0] = casc ? ok_now[1] : legal_src(mode[0], ck[0], slow_power_mode, 1'b0); // RL19

  assign inc[0] = go[0] & ok_now[0] & taps[ck[0]]; // RL6
  assign inc[1] = go[1] & ok_now[1] & (mode[1][2] ? carry[0] : taps[ck[1]]); // RL7

  // 8-bit match in timer, event and divider modes
  generate
    for (gi = 0; gi < 2; gi++) begin : g_m8
      assign match8[gi] = inc[gi] && !mode[gi][2] && (mode[gi] != MODE_PWM8) &&
                          (mode[gi] != MODE_CASC_LO) && (cnt_nx[gi] == per_q[gi]); // RL17
    end
  endgenerate

  // Warm-up compares only the upper byte of the period
  assign c16    = {cnt[1], cnt[0]};
  assign c16_nx = c16 + 16'h0001;
  assign w16    = {wid_q[1], wid_q[0]};
  assign tgt16  = (mode[1] == MODE_WARM) ? {per_q[1], 8'h00} : {per_q[1], per_q[0]};
  assign m16    = casc && inc[0] && (mode[1] != MODE_PWM16) && (c16_nx == tgt16);

  assign clr[0] = casc ? m16 : match8[0]; // RL17
  assign clr[1] = casc ? m16 : match8[1]; // RL17

  generate
    for (gi = 0; gi < 2; gi++) begin : g_cnt
      cdt_count8 u_cnt (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .inc     (inc[gi]),
        .clr     (clr[gi]),
        .cnt     (cnt[gi]),
        .carry   (carry[gi])
      );
    end
  endgenerate

  // Interrupt events
  assign ev[ST_MATCH_LO] = !casc && (match8[0] || (mode[0] == MODE_PWM8 && carry[0])); // RL17
  assign ev[ST_MATCH_HI] = casc ? (m16 || (mode[1] == MODE_PWM16 && carry[1]))
                                : (match8[1] || (mode[1] == MODE_PWM8 && carry[1])); // RL17
  assign ev[ST_ILLEGAL]  = |start_bad; // RL19

  // Waveforms; in cascade the upper flip-flop drives the pin
  assign wave_lo = (mode[0] == MODE_PDO)  ? ~ctl_q[0][CTL_FF_BIT] :
                   (mode[0] == MODE_PWM8) ? ctl_q[0][CTL_FF_BIT] ^ (cnt[0] < wid_q[0]) :
                                            ctl_q[0][CTL_FF_BIT];
  assign wave_hi = (mode[1] == MODE_PDO)   ? ~ctl_q[1][CTL_FF_BIT] :
                   (mode[1] == MODE_PWM8)  ? ctl_q[1][CTL_FF_BIT] ^ (cnt[1] < wid_q[1]) :
                   (mode[1] == MODE_PWM16) ? ctl_q[1][CTL_FF_BIT] ^ (c16 < w16) :
                   (mode[1] == MODE_PPG16) ? ctl_q[1][CTL_FF_BIT] ^ (c16 >= w16) :
                                             ctl_q[1][CTL_FF_BIT]; // RL6

  // Register port decode
  generate
    for (gi = 0; gi < 2; gi++) begin : g_reg
      logic [2:0] chk_ck;
      assign ctl_wr[gi]    = reg_wr && (reg_addr == (gi == 0 ? REG_CTL_LO : REG_CTL_HI));
      assign chk_ck        = (gi == 1 && reg_wdata[CTL_MODE_LSB + 2]) ? ck[0]
                                                                      : reg_wdata[CTL_CK_LSB +: 3];
      assign start_bad[gi] = ctl_wr[gi] && reg_wdata[CTL_RUN_BIT] && !run[gi] &&
                             !legal_src(reg_wdata[CTL_MODE_LSB +: 3], chk_ck,
                                        slow_power_mode, gi == 1); // RL19

      // Fields stored as written, less the run bit on an illegal start; stable fields while running are up to software
      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          ctl_q[gi] <= CTL_RST;
        end else if (ctl_wr[gi]) begin
          ctl_q[gi] <= start_bad[gi] ? (reg_wdata & ~(8'h01 << CTL_RUN_BIT)) : reg_wdata; // RL1 RL19 RL3 RL4
        end else if (match8[gi] && mode[gi] == MODE_PDO) begin
          ctl_q[gi][CTL_FF_BIT] <= ~ctl_q[gi][CTL_FF_BIT];
        end
      end

      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          per_q[gi] <= PER_RST;
          wid_q[gi] <= WID_RST;
        end else begin
          if (reg_wr && reg_addr == (gi == 0 ? REG_PER_LO : REG_PER_HI)) begin
            per_q[gi] <= reg_wdata; // RL1
          end
          if (reg_wr && reg_addr == (gi == 0 ? REG_WID_LO : REG_WID_HI)) begin
            wid_q[gi] <= reg_wdata; // RL1
          end
        end
      end
    end
  endgenerate

  // Reading status clears it, but a same-cycle event still lands
  assign stat_d = (stat_q & ~((reg_rd && reg_addr == REG_STAT) ? {ST_W{1'b1}} : {ST_W{1'b0}})) | ev;

  assign rd_mux = (reg_addr == REG_CTL_LO) ? ctl_q[0] :
                  (reg_addr == REG_CTL_HI) ? ctl_q[1] :
                  (reg_addr == REG_PER_LO) ? per_q[0] :
                  (reg_addr == REG_PER_HI) ? per_q[1] :
                  (reg_addr == REG_WID_LO) ? wid_q[0] :
                  (reg_addr == REG_WID_HI) ? wid_q[1] :
                  (reg_addr == REG_AUX)    ? aux_q :
                  (reg_addr == REG_STAT)   ? {5'h00, stat_q} :
                  (reg_addr == REG_MASK)   ? {5'h00, mask_q} :
                  (reg_addr == REG_CNT_LO) ? cnt[0] :
                  (reg_addr == REG_CNT_HI) ? cnt[1] : 8'h00;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      aux_q    <= AUX_RST;
      mask_q   <= MASK_RST;
      stat_q   <= STAT_RST;
      rdata_q  <= 8'h00;
      pin_q    <= 1'b1;
      out_lo_q <= 1'b0;
      out_hi_q <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == REG_AUX) begin
        aux_q <= reg_wdata;
      end
      if (reg_wr && reg_addr == REG_MASK) begin
        mask_q <= reg_wdata[ST_W-1:0];
      end
      stat_q   <= stat_d;
      rdata_q  <= reg_rd ? rd_mux : 8'h00;
      pin_q    <= upper_pin_in;
      out_lo_q <= wave_lo;
      out_hi_q <= aux_q[AUX_REDIR_BIT] ? 1'b0 : wave_hi; // RL8
    end
  end

  assign reg_rdata       = rdata_q;
  assign lower_timer_out = out_lo_q;
  assign upper_timer_out = out_hi_q;
  assign irq             = |(stat_q & mask_q);

  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  property p_period_write;
    reg_wr && reg_addr == REG_PER_LO |=> per_q[0] == $past(reg_wdata);
  endproperty
  a_period_write: assert property (p_period_write) else $error("period write lost"); // RL1

  property p_timer_match;
    match8[0] |=> cnt[0] == 8'h00 && stat_q[ST_MATCH_LO];
  endproperty
  a_timer_match: assert property (p_timer_match) else $error("match did not clear or flag"); // RL17

  property p_event_edge;
    go[1] && mode[1] == MODE_TIMER && ck[1] == CK_PIN && pin_q && !upper_pin_in && !clr[1]
      |=> cnt[1] == $past(cnt[1]) + 8'h01;
  endproperty
  a_event_edge: assert property (p_event_edge) else $error("falling edge not counted"); // RL18

  property p_casc_clock;
    $past(mode[1][2]) && !$past(clr[1]) && $changed(cnt[1]) |-> $past(carry[0]);
  endproperty
  a_casc_clock: assert property (p_casc_clock) else $error("upper moved without lower overflow"); // RL7

  property p_casc_run;
    casc && !run[1] |=> $stable(cnt[0]);
  endproperty
  a_casc_run: assert property (p_casc_run) else $error("lower ran without upper run"); // RL6

  property p_redirect;
    aux_q[AUX_REDIR_BIT] |=> !upper_timer_out;
  endproperty
  a_redirect: assert property (p_redirect) else $error("pulse seen while redirected"); // RL8

  property p_illegal_start;
    start_bad[1] |=> !run[1] ##0 stat_q[ST_ILLEGAL] ##1 1'b1;
  endproperty
  a_illegal_start: assert property (p_illegal_start) else $error("illegal start accepted"); // RL19

  property p_slow_fc;
    slow_power_mode && inc[0] && ck[0] == CK_FC |-> casc && mode[1] == MODE_WARM;
  endproperty
  a_slow_fc: assert property (p_slow_fc) else $error("fc used outside warm-up in slow"); // RL9

  property p_normal_taps;
    !slow_power_mode && inc[0] && !casc && mode[0] == MODE_TIMER |-> ck[0] <= CK_TAP3;
  endproperty
  a_normal_taps: assert property (p_normal_taps) else $error("bad tap in normal mode"); // RL10

  property p_slow_taps;
    slow_power_mode && inc[1] && mode[1] == MODE_PDO |-> ck[1] == CK_TAP0;
  endproperty
  a_slow_taps: assert property (p_slow_taps) else $error("bad tap in slow mode"); // RL11

  property p_lower_no16;
    inc[0] && !casc |-> !mode[0][2];
  endproperty
  a_lower_no16: assert property (p_lower_no16) else $error("lower counted alone in 16-bit mode"); // RL19

  property p_illegal_sticky;
    stat_q[ST_ILLEGAL] && !(reg_rd && reg_addr == REG_STAT) |=> stat_q[ST_ILLEGAL];
  endproperty
  a_illegal_sticky: assert property (p_illegal_sticky) else $error("illegal flag lost before read"); // RL19

  property p_match16_clear;
    m16 |=> c16 == 16'h0000 && stat_q[ST_MATCH_HI];
  endproperty
  a_match16_clear: assert property (p_match16_clear) else $error("16-bit match did not clear or flag"); // RL17

  c_match_hi: cover property (match8[1]);
  c_m16:      cover property (m16);
  c_illegal:  cover property (start_bad[0] || start_bad[1]);
  c_irq:      cover property (irq && reg_rd && reg_addr == REG_STAT);
  c_warm:     cover property (m16 && mode[1] == MODE_WARM);
endmodule

// >>> sim/cascadable_dual_timer_control_bench.sv
// Self-checking bench for the cascadable dual timer
`timescale 1ns/10ps
module cascadable_dual_timer_control_bench;
  import cdt_pkg::*;
  logic                clk_sys = 1'b0;
  logic                rst_b = 1'b0;
  logic [ADDR_W-1:0]   reg_addr = '0;
  logic [DATA_W-1:0]   reg_wdata = '0;
  logic                reg_wr = 1'b0;
  logic                reg_rd = 1'b0;
  logic [DATA_W-1:0]   reg_rdata;
  logic                slow_power_mode = 1'b0;
  logic [NUM_TAPS-1:0] src_tick = '0;
  logic                upper_pin_in = 1'b1;
  logic                lower_timer_out;
  logic                upper_timer_out;
  logic                irq;
  int                  fail_count = 0;
  int                  check_count = 0;
  int                  m_cnt;
  int                  per;
  int                  tog;
  logic [7:0]          v;
  logic                ev;

  always #4 clk_sys = ~clk_sys;

  cdt_timer_top i_cdt_timer_top (
    .clk_sys         (clk_sys),
    .rst_b           (rst_b),
    .reg_addr        (reg_addr),
    .reg_wdata       (reg_wdata),
    .reg_wr          (reg_wr),
    .reg_rd          (reg_rd),
    .reg_rdata       (reg_rdata),
    .slow_power_mode (slow_power_mode),
    .src_tick        (src_tick),
    .upper_pin_in    (upper_pin_in),
    .lower_timer_out (lower_timer_out),
    .upper_timer_out (upper_timer_out),
    .irq             (irq)
  );

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic rchk(input logic [3:0] a, input logic [7:0] exp, input string msg);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp, msg);
  endtask

  // Mid-run reset; brings the counters back to zero without waiting for a match
  task automatic reset_dut();
    @(posedge clk_sys);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
  endtask

  // Ticks held for n cycles, one count per cycle
  task automatic ticks(input int k, input int n);
    @(posedge clk_sys);
    src_tick[k] <= 1'b1;
    repeat (n) @(posedge clk_sys);
    src_tick[k] <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask

  // Source legality per mode and power mode
  function automatic bit legal(input int m, input int k, input bit slow, input bit up);
    if (k == 7) return up && m == 0;
    if (m == 2) return slow ? (k == 0 || k == 4) : (k <= 5);
    return slow ? (k == 0) : (k <= 3);
  endfunction

  initial begin
    #(8 * 30000);
    fail_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    conclude();
  end

  initial begin
    void'($urandom(89540));
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    // Reset values, unmapped indices read zero
    rchk(REG_CTL_LO, CTL_RST, "ctl lo");
    rchk(REG_CTL_HI, CTL_RST, "ctl hi");
    rchk(REG_PER_LO, PER_RST, "per lo");
    rchk(REG_PER_HI, PER_RST, "per hi");
    rchk(REG_WID_LO, WID_RST, "wid lo");
    rchk(REG_WID_HI, WID_RST, "wid hi");
    rchk(REG_AUX, AUX_RST, "aux");
    rchk(REG_STAT, 8'h00, "stat");
    rchk(REG_MASK, 8'h00, "mask");
    wr(4'hC, 8'h5A);
    rchk(4'hC, 8'h00, "unmapped");
    $display("test reset done");

    // Timer match: event, clear, resume; interrupt masked and unmasked
    per = 2 + ($urandom % 6);
    m_cnt = 0;
    wr(REG_PER_LO, per[7:0]);
    wr(REG_MASK, 8'h01);
    wr(REG_CTL_LO, 8'h08);
    for (int i = 0; i < 2 * per + 1; i++) begin
      ticks(0, 1);
      m_cnt++;
      ev = (m_cnt == per);
      if (ev) m_cnt = 0;
      rchk(REG_CNT_LO, m_cnt[7:0], "lower count");
      chk({7'h0, irq}, {7'h0, ev}, "irq level");
      rchk(REG_STAT, {7'h0, ev}, "match status");
    end
    wr(REG_MASK, 8'h00);
    ticks(0, per);
    chk({7'h0, irq}, 8'h00, "masked irq");
    rchk(REG_STAT, 8'h01, "masked status");
    wr(REG_CTL_LO, 8'h00);
    $display("test timer done");

    // Event counter on the upper pin, falling edges only
    wr(REG_CTL_HI, 8'h78);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_sys);
      upper_pin_in <= 1'b0;
      repeat (3) @(posedge clk_sys);
      upper_pin_in <= 1'b1;
      repeat (3) @(posedge clk_sys);
    end
    rchk(REG_CNT_HI, 8'h05, "event count");
    wr(REG_CTL_HI, 8'h70);
    rd(REG_STAT, v);
    $display("test event done");

    // Start legality for the timer, divider and 8-bit PWM modes and every source in both power modes
    for (int p = 0; p < 2; p++) begin
      slow_power_mode <= p[0];
      for (int c = 0; c < 2; c++) begin
        for (int m = 0; m < 3; m++) begin
          for (int k = 0; k < 8; k++) begin
            ev = legal(m, k, p[0], c[0]);
            wr(c[3:0], {1'b0, k[2:0], 1'b1, m[2:0]});
            rchk(c[3:0], {1'b0, k[2:0], ev, m[2:0]}, "start run");
            rchk(REG_STAT, ev ? 8'h00 : 8'h04, "illegal flag");
            wr(c[3:0], {1'b0, k[2:0], 1'b0, m[2:0]});
          end
        end
      end
    end
    slow_power_mode <= 1'b0;
    $display("test legality done");

    // Counters start the cascade from zero
    reset_dut();
    rchk(REG_PER_HI, PER_RST, "per hi after reset");
    rchk(REG_CNT_HI, 8'h00, "count hi after reset");

    // Cascade: lower source, upper run, upper clocked by lower carry
    tog = 250 + ($urandom % 100);
    wr(REG_PER_LO, 8'h80);
    wr(REG_PER_HI, 8'h01);
    wr(REG_CTL_LO, 8'h03);
    wr(REG_CTL_HI, 8'h7C);
    ticks(0, tog);
    rchk(REG_CNT_LO, tog[7:0], "cascade lo");
    rchk(REG_CNT_HI, tog[15:8], "cascade hi");
    rchk(REG_CTL_HI, 8'h7C, "cascade run");
    rd(REG_STAT, v);
    chk(v & 8'h04, 8'h00, "cascade legal");
    wr(REG_CTL_HI, 8'h74);
    wr(REG_CTL_LO, 8'h00);
    $display("test cascade done");

    // Redirect bit holds the upper pin quiet in divider mode
    wr(REG_PER_HI, 8'h02);
    wr(REG_AUX, 8'h01);
    wr(REG_CTL_HI, 8'h09);
    @(posedge clk_sys);
    src_tick[0] <= 1'b1;
    repeat (20) begin
      @(posedge clk_sys);
      #1 chk({7'h0, upper_timer_out}, 8'h00, "redirected pin");
    end
    wr(REG_AUX, 8'h00);
    tog = 0;
    #1 v[0] = upper_timer_out;
    repeat (20) begin
      @(posedge clk_sys);
      #1 if (upper_timer_out !== v[0]) tog++;
      v[0] = upper_timer_out;
    end
    src_tick[0] <= 1'b0;
    chk({7'h0, tog >= 5}, 8'h01, "pin toggles");
    // Stop write keeps the toggled flip-flop as it stands
    rd(REG_CTL_HI, v);
    wr(REG_CTL_HI, v & 8'hF7);
    $display("test redirect done");

    // Warm-up: fc only in slow, then a 256-tick match on fs
    reset_dut();
    wr(REG_MASK, 8'h02);
    wr(REG_CTL_LO, 8'h63);
    wr(REG_CTL_HI, 8'h0D);
    rchk(REG_CTL_HI, 8'h05, "fc warm-up in normal");
    rchk(REG_STAT, 8'h04, "fc warm-up flag");
    slow_power_mode <= 1'b1;
    wr(REG_CTL_HI, 8'h0D);
    rchk(REG_CTL_HI, 8'h0D, "fc warm-up in slow");
    wr(REG_CTL_HI, 8'h05);
    slow_power_mode <= 1'b0;
    wr(REG_PER_HI, 8'h01);
    wr(REG_CTL_LO, 8'h43);
    wr(REG_CTL_HI, 8'h0D);
    ticks(4, 255);
    chk({7'h0, irq}, 8'h00, "warm-up early");
    ticks(4, 1);
    chk({7'h0, irq}, 8'h01, "warm-up match irq");
    rchk(REG_CNT_HI, 8'h00, "warm-up cleared");
    rchk(REG_STAT, 8'h02, "warm-up status");
    wr(REG_CTL_HI, 8'h05);
    $display("test warm-up done");

    // 16-bit pulse generator: width 2, period 5
    wr(REG_CTL_LO, 8'h03);
    wr(REG_PER_LO, 8'h05);
    wr(REG_PER_HI, 8'h00);
    wr(REG_WID_LO, 8'h02);
    wr(REG_CTL_HI, 8'h0F);
    ticks(0, 1);
    #1 v[0] = upper_timer_out;
    ticks(0, 1);
    #1 chk({7'h0, upper_timer_out ^ v[0]}, 8'h01, "ppg edge at width");
    ticks(0, 3);
    rchk(REG_CNT_LO, 8'h00, "ppg period");
    rchk(REG_STAT, 8'h02, "ppg match");
    wr(REG_CTL_HI, 8'h07);

    // 16-bit pulse width: edge once the count reaches width 3
    wr(REG_WID_LO, 8'h03);
    wr(REG_CTL_HI, 8'h0E);
    ticks(0, 2);
    #1 v[0] = upper_timer_out;
    ticks(0, 1);
    #1 chk({7'h0, upper_timer_out ^ v[0]}, 8'h01, "pwm edge at width");
    wr(REG_CTL_HI, 8'h06);
    $display("test 16-bit modes done");
    conclude();
  end
endmodule
